// ===== wosl_lock.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (RQ1) full erase, program, verify over debug ports
// (RQ2) protection lowered only by full erase; a reset here also clears it to PROT_RST
// (RQ3) block operations gated by block security
// (RQ4) 32-bit latch with loadable volatile copy
// (RQ5) verdict one when 28 bits match
// (RQ6) locked verdict disables all debug ports
// (RQ7) locked verdict freezes latch contents forever
// (RQ8) lock needs load, program, then reset
// (RQ9) verdict sampled only during reset
// (RQ10) key write only without flash protection
// (RQ11) access stays until next reset
// (RQ12) latch readable through the serial debug port
// (RQ13) lock state changes only at reset
module wosl_lock #(
	parameter int OP_CYCLES = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register port from the debug access logic
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_swd_i,
	output logic [31:0] reg_rdata_o,
	// port gating
	output logic jtag_en_o,
	output logic swd_en_o,
	output logic test_en_o,
	output logic locked_o
);
	import wosl_pkg::*;
	wosl_flash_if fl ();
	logic [31:0] vcopy; // volatile copy of the latch
	// nonvolatile latch cells; they start erased so a fresh part samples a clean open verdict
	logic [31:0] cells = 32'h0000_0000;
	logic [7:0] prot; // flash protection level
	logic [7:0] blksec; // per-block permit bits
	logic [BLK_W-1:0] blk; // block index for block commands
	logic locked; // reset-sampled verdict
	logic refused; // last command refused
	logic done_flag; // sticky operation done
	logic verdict; // live wrapper output
	logic [31:0] rdata;
	logic jtag_en, swd_en, test_en;
	logic [31:0] next_vcopy, next_cells, next_rdata;
	logic [7:0] next_prot, next_blksec;
	logic [BLK_W-1:0] next_blk;
	logic next_refused, next_done_flag;
	logic next_start;
	logic [2:0] next_cmd;
	logic start_q;
	logic [2:0] cmd_q;
	logic access_ok; // bus requests accepted
	logic cmd_wr; // command write this cycle
	logic op_ok; // command allowed
	// majority vote over the cells
	wosl_vote u_vote (
		.cells_i(cells),
		.match_o(verdict)
	);
	// flash operation sequencer
	wosl_seq #(.OP_CYCLES(OP_CYCLES)) u_seq (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.fl(fl)
	);
	assign fl.start = start_q;
	assign fl.cmd = cmd_q;
	assign fl.blk = blk;
	// lock state: loaded only while reset is held, so writing the latch changes nothing now
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			locked <= verdict; // RQ9 RQ13 RQ8
		end
	end
	// while locked the register port ignores every request except serial reads of the cells, even after a later key write
	assign access_ok = ~locked; // RQ6 RQ11
	assign cmd_wr = access_ok && reg_wr_i && reg_addr_i == OFS_CMD;
	// decide whether the requested command may run
	always_comb begin
		op_ok = 1'b0;
		case (reg_wdata_i[2:0])
			CMD_FULL_ERASE: op_ok = 1'b1; // RQ1
			CMD_BLK_ERASE, CMD_BLK_PROG, CMD_BLK_VERIFY:
				op_ok = blksec[blk]; // RQ3
			CMD_LATCH_PROG: op_ok = (prot == PROT_RST) && ~locked; // RQ10 RQ7
			default: op_ok = 1'b0;
		endcase
		if (fl.busy) begin
			op_ok = 1'b0; // one operation at a time
		end
	end
	// next values of the register file
	always_comb begin
		next_vcopy = vcopy;
		next_cells = cells;
		next_prot = prot;
		next_blksec = blksec;
		next_blk = blk;
		next_refused = refused;
		next_done_flag = done_flag;
		next_start = 1'b0;
		next_cmd = cmd_q;
		next_rdata = 32'h0000_0000;
		if (access_ok && reg_wr_i) begin
			if (reg_addr_i == OFS_VCOPY) begin
				next_vcopy = reg_wdata_i; // RQ4
			end else if (reg_addr_i == OFS_PROT) begin
				// raising only; lowering waits for a full erase or a reset
				if (reg_wdata_i[7:0] >= prot) begin
					next_prot = reg_wdata_i[7:0]; // RQ2
				end
			end else if (reg_addr_i == OFS_BLKSEC) begin
				next_blksec = reg_wdata_i[7:0];
			end else if (reg_addr_i == OFS_ADDR) begin
				next_blk = reg_wdata_i[BLK_W-1:0];
			end else if (reg_addr_i == OFS_CTRL) begin
				// write one clears status flags
				if (reg_wdata_i[ST_REFUSED]) begin
					next_refused = 1'b0;
				end
				if (reg_wdata_i[ST_DONE]) begin
					next_done_flag = 1'b0;
				end
			end
		end
		if (cmd_wr) begin
			next_refused = ~op_ok;
			if (op_ok) begin
				next_start = 1'b1;
				next_cmd = reg_wdata_i[2:0];
			end
		end
		// completion effects; set wins over clear
		if (fl.done) begin
			next_done_flag = 1'b1;
			if (cmd_q == CMD_FULL_ERASE) begin
				next_prot = PROT_RST; // RQ2 RQ1
				next_blksec = BLKSEC_RST;
			end else if (cmd_q == CMD_LATCH_PROG) begin
				next_cells = vcopy; // RQ8 RQ4
			end
		end
		// reads: the latch stays readable over the serial debug port even when locked for identification
		if (reg_rd_i) begin
			if (reg_addr_i == OFS_CELLS && (access_ok || reg_swd_i)) begin
				next_rdata = cells; // RQ12
			end else if (access_ok) begin
				if (reg_addr_i == OFS_STATUS) begin
					next_rdata[ST_LOCKED] = locked;
					next_rdata[ST_VERDICT] = verdict;
					next_rdata[ST_BUSY] = fl.busy;
					next_rdata[ST_REFUSED] = refused;
					next_rdata[ST_DONE] = done_flag;
				end else if (reg_addr_i == OFS_VCOPY) begin
					next_rdata = vcopy;
				end else if (reg_addr_i == OFS_PROT) begin
					next_rdata = {24'h000000, prot};
				end else if (reg_addr_i == OFS_BLKSEC) begin
					next_rdata = {24'h000000, blksec};
				end else if (reg_addr_i == OFS_ADDR) begin
					next_rdata = {{(32 - BLK_W){1'b0}}, blk};
				end
			end
		end
	end
	// port enables follow the sampled lock
	always_comb begin
		jtag_en = ~locked; // RQ6
		swd_en = ~locked; // RQ6
		test_en = ~locked; // RQ6
	end
	// register everything; cells hold no reset since they model nonvolatile storage
	always_ff @(posedge core_clk_i) begin
		cells <= next_cells;
		if (rst_i) begin
			vcopy <= 32'h0000_0000;
			prot <= PROT_RST;
			blksec <= BLKSEC_RST;
			blk <= '0;
			refused <= 1'b0;
			done_flag <= 1'b0;
			start_q <= 1'b0;
			cmd_q <= 3'h0;
			rdata <= 32'h0000_0000;
			jtag_en_o <= 1'b0;
			swd_en_o <= 1'b0;
			test_en_o <= 1'b0;
			locked_o <= 1'b0;
		end else begin
			vcopy <= next_vcopy;
			prot <= next_prot;
			blksec <= next_blksec;
			blk <= next_blk;
			refused <= next_refused;
			done_flag <= next_done_flag;
			start_q <= next_start;
			cmd_q <= next_cmd;
			rdata <= next_rdata;
			jtag_en_o <= jtag_en;
			swd_en_o <= swd_en;
			test_en_o <= test_en;
			locked_o <= locked;
		end
	end
	assign reg_rdata_o = rdata;
endmodule : wosl_lock
`default_nettype wire

// ===== wosl_pkg.sv
package wosl_pkg;
	// key pattern the latch wrapper compares against; value is arbitrary
	localparam logic [31:0] KEY_PATTERN = 32'hA5C3_3C5A;
	// least count of matching bits for a lock verdict
	localparam logic [5:0] MATCH_MIN = 6'h1C;
	// register offsets on the plain register port
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_VCOPY = 4'h2;
	localparam logic [3:0] OFS_CELLS = 4'h3;
	localparam logic [3:0] OFS_PROT = 4'h4;
	localparam logic [3:0] OFS_BLKSEC = 4'h5;
	localparam logic [3:0] OFS_CMD = 4'h6;
	localparam logic [3:0] OFS_ADDR = 4'h7;
	// command codes written to the command register
	localparam logic [2:0] CMD_FULL_ERASE = 3'h1;
	localparam logic [2:0] CMD_BLK_ERASE = 3'h2;
	localparam logic [2:0] CMD_BLK_PROG = 3'h3;
	localparam logic [2:0] CMD_BLK_VERIFY = 3'h4;
	localparam logic [2:0] CMD_LATCH_PROG = 3'h5;
	// status bit positions
	localparam int ST_LOCKED = 0;
	localparam int ST_VERDICT = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_DONE = 4;
	// reset values
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] BLKSEC_RST = 8'hFF;
	// width of the flash block index
	localparam int BLK_W = 3;
endpackage : wosl_pkg

// ===== wosl_flash_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries flash operation requests to the flash operation sequencer
interface wosl_flash_if;
	import wosl_pkg::*;
	logic start; // one-cycle start pulse
	logic [2:0] cmd; // operation code
	logic [BLK_W-1:0] blk; // target block index
	logic busy; // sequencer running
	logic done; // one-cycle completion pulse
	modport master (output start, output cmd, output blk, input busy, input done);
	modport slave (input start, input cmd, input blk, output busy, output done);
endinterface : wosl_flash_if
`default_nettype wire

// ===== wosl_vote.sv
`timescale 1ns/1ns
`default_nettype none
// majority-vote wrapper around the nonvolatile latch cells
module wosl_vote (
	// latch contents
	input wire logic [31:0] cells_i,
	// verdict
	output logic match_o
);
	import wosl_pkg::*;
	logic [31:0] agree; // per-bit agreement with the key
	logic [5:0] count; // number of agreeing bits
	// compare each bit with the key
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_bit
			assign agree[g] = ~(cells_i[g] ^ KEY_PATTERN[g]);
		end
	endgenerate
	// count agreeing bits; an exact match is not required so a few failed cells still lock
	always_comb begin
		count = 6'h00;
		for (int i = 0; i < 32; i++) begin
			count = count + {5'h00, agree[i]};
		end
		match_o = (count >= MATCH_MIN); // RQ5
	end
endmodule : wosl_vote
`default_nettype wire

// ===== wosl_seq.sv
`timescale 1ns/1ns
`default_nettype none
// flash operation sequencer: runs one operation for a fixed number of cycles
module wosl_seq #(
	parameter int OP_CYCLES = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// request side
	wosl_flash_if.slave fl
);
	import wosl_pkg::*;
	logic [7:0] cnt; // remaining cycles
	logic [7:0] next_cnt;
	logic done_q; // completion pulse
	logic next_done;
	// next state: load on start, count down while busy
	always_comb begin
		next_cnt = cnt;
		next_done = 1'b0;
		if (fl.start && cnt == 8'h00) begin
			next_cnt = OP_CYCLES[7:0];
		end else if (cnt != 8'h00) begin
			next_cnt = cnt - 8'h01;
			next_done = (cnt == 8'h01);
		end
	end
	// register
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			done_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			done_q <= next_done;
		end
	end
	assign fl.busy = (cnt != 8'h00);
	assign fl.done = done_q;
endmodule : wosl_seq
`default_nettype wire

// ===== wosl_lock_chk.sv
`timescale 1ns/1ns
`default_nettype none
// watches port gating and read answers
module wosl_lock_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_swd_i,
	input wire logic [31:0] reg_rdata_o,
	// gating
	input wire logic jtag_en_o,
	input wire logic swd_en_o,
	input wire logic test_en_o,
	input wire logic locked_o
);
	import wosl_pkg::*;
	logic [1:0] up; // edges since release, saturating
	logic [1:0] next_up;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// outputs settle one edge after release, so early edges are skipped
	always_comb begin
		next_up = rst_i ? 2'h0 : up + {1'b0, up != 2'h3};
	end
	always_ff @(posedge core_clk_i) begin
		up <= next_up;
	end
	property p_en; up != 2'h0 |-> jtag_en_o == !locked_o; endproperty
	a_en: assert property (p_en) else $error("enable not inverse of lock");
	property p_same; up != 2'h0 |-> swd_en_o == jtag_en_o && test_en_o == jtag_en_o; endproperty
	a_same: assert property (p_same) else $error("port enables differ");
	property p_stable; up[1] |-> $stable(locked_o); endproperty
	a_stable: assert property (p_stable) else $error("lock moved outside reset");
	property p_idle; up != 2'h0 && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_shut; locked_o && reg_rd_i && !(reg_swd_i && reg_addr_i == OFS_CELLS)
		|=> reg_rdata_o == 32'h0; endproperty
	a_shut: assert property (p_shut) else $error("locked part answered");
	property p_swd; locked_o && reg_rd_i && reg_swd_i && reg_addr_i == OFS_CELLS
		|=> $countones(~(reg_rdata_o ^ KEY_PATTERN)) >= MATCH_MIN; endproperty
	a_swd: assert property (p_swd) else $error("cell readout not a key");
	property p_stat; up[1] && reg_rd_i && reg_addr_i == OFS_STATUS && !locked_o
		|=> !reg_rdata_o[ST_LOCKED]; endproperty
	a_stat: assert property (p_stat) else $error("status shows lock");
	property p_vcopy; !locked_o && reg_wr_i && reg_addr_i == OFS_VCOPY ##2 reg_rd_i
		&& reg_addr_i == OFS_VCOPY |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
	a_vcopy: assert property (p_vcopy) else $error("copy readback wrong");
endmodule : wosl_lock_chk
bind wosl_lock wosl_lock_chk wosl_lock_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_swd_i(reg_swd_i), .reg_rdata_o(reg_rdata_o),
	.jtag_en_o(jtag_en_o), .swd_en_o(swd_en_o), .test_en_o(test_en_o), .locked_o(locked_o));
`default_nettype wire

// ===== wosl_prog.sv
`timescale 1ns/1ns
`default_nettype none
// debug programmer: strobes and write data just after an edge, read data a cycle later
module wosl_prog (
	// clock
	input wire logic core_clk_i,
	// register port toward the device
	output logic [3:0] reg_addr_o = 4'h0,
	output logic [31:0] reg_wdata_o = 32'h0,
	output logic reg_wr_o = 1'b0,
	output logic reg_rd_o = 1'b0,
	output logic reg_swd_o = 1'b0,
	input wire logic [31:0] reg_rdata_i
);
	// write; data turns to its inverse once released, so stale data never helps
	task automatic wr(input logic [3:0] a, input logic [31:0] x);
		@(posedge core_clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= x;
		reg_wr_o <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~x;
	endtask : wr
	// read; the answer is taken mid-cycle while it stands, clear of the edge that ends it
	task automatic rd(input logic [3:0] a, input logic s, output logic [31:0] x);
		@(posedge core_clk_i);
		reg_addr_o <= a;
		reg_swd_o <= s;
		reg_rd_o <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_o <= 1'b0;
		@(negedge core_clk_i);
		x = reg_rdata_i;
	endtask : rd
endmodule : wosl_prog
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
// programmer model drives, integer model predicts
module testbench;
	import wosl_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] ad;
	logic [31:0] wd, rdat, v, d, cells; // cells: model of the latch
	logic [63:0] m;
	logic wr, rd, swd, jen, sen, ten, lck;
	int errors = 0;
	int num_checks = 0;
	int seed = 33051;
	always #2 core_clk_i = ~core_clk_i;
	wosl_lock wosl_lock_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(ad),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_swd_i(swd), .reg_rdata_o(rdat),
		.jtag_en_o(jen), .swd_en_o(sen), .test_en_o(ten), .locked_o(lck));
	wosl_prog wosl_prog_inst (.core_clk_i(core_clk_i), .reg_addr_o(ad), .reg_wdata_o(wd),
		.reg_wr_o(wr), .reg_rd_o(rd), .reg_swd_o(swd), .reg_rdata_i(rdat));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict();
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic w(input logic [3:0] a, input logic [31:0] x);
		wosl_prog_inst.wr(a, x);
	endtask : w
	task automatic rc(input logic [3:0] a, input logic s, input logic [31:0] e);
		wosl_prog_inst.rd(a, s, d);
		chk(d, e);
	endtask : rc
	// clear sticky flags, issue a command, poll until done or refused
	task automatic op(input int c);
		w(OFS_CTRL, 32'h18);
		w(OFS_CMD, 32'(c));
		d = 32'h0;
		for (int i = 0; i < 12 && !d[ST_DONE] && !d[ST_REFUSED]; i++) begin
			wosl_prog_inst.rd(OFS_STATUS, 1'b0, d);
		end
	endtask : op
	task automatic reset();
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
	endtask : reset
	// every port follows the expected lock
	task automatic gate(input logic e);
		chk({lck, jen, sen, ten}, {e, !e, !e, !e});
	endtask : gate
	initial begin
		reset();
		rc(4'h9, 1'b0, 32'h0);
		rc(OFS_BLKSEC, 1'b0, 32'(BLKSEC_RST));
		// cells power up erased to zero, and a random value goes in first
		v = $random(seed);
		w(OFS_VCOPY, v);
		rc(OFS_VCOPY, 1'b0, v);
		op(CMD_LATCH_PROG);
		cells = v;
		rc(OFS_CELLS, 1'b0, cells);
		w(OFS_PROT, 32'h0F);
		w(OFS_PROT, 32'h03);
		rc(OFS_PROT, 1'b0, 32'h0F);
		// protection set first: the key write must bounce
		w(OFS_VCOPY, KEY_PATTERN);
		op(CMD_LATCH_PROG);
		chk(d[ST_REFUSED], 1'b1);
		rc(OFS_CELLS, 1'b0, cells);
		w(OFS_BLKSEC, 32'hFE);
		for (int b = 0; b < 2; b++) begin
			for (int c = 2; c < 5; c++) begin
				w(OFS_ADDR, 32'(b));
				op(c);
				chk({d[ST_REFUSED], d[ST_DONE]}, {b == 0, b == 1});
			end
		end
		op(CMD_FULL_ERASE);
		rc(OFS_PROT, 1'b0, 32'h0);
		rc(OFS_BLKSEC, 1'b0, 32'hFF);
		// key loaded but never programmed: reset follows the old cells
		w(OFS_VCOPY, KEY_PATTERN);
		reset();
		gate($countones(cells ^ KEY_PATTERN) <= 4);
		// 27 matching bits stay open, 28 lock
		for (int k = 5; k > 3; k--) begin
			m = {2{(32'h1 << k) - 32'h1}} >> ($unsigned($random(seed)) % 32);
			cells = KEY_PATTERN ^ m[31:0];
			w(OFS_VCOPY, cells);
			op(CMD_LATCH_PROG);
			gate(1'b0);
			reset();
			gate($countones(cells ^ KEY_PATTERN) <= 4);
		end
		rc(OFS_CELLS, 1'b1, cells);
		rc(OFS_CELLS, 1'b0, 32'h0);
		w(OFS_VCOPY, 32'h0);
		op(CMD_LATCH_PROG);
		op(CMD_FULL_ERASE);
		reset();
		gate(1'b1);
		rc(OFS_CELLS, 1'b1, cells);
		print_verdict();
	end
	// a hang counts as a mismatch
	initial begin
		#40000;
		errors++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
